// ---- rtl/phy_datapath_bist_and_monitors.sv ----
`include "bist_defs.svh"

module phy_datapath_bist_and_monitors
    import bist_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic por_n,
    input wire logic reg_req,
    input wire logic reg_we,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_ack,
    input wire stream_t mac_tx_in,
    input wire stream_t line_rx_in,
    output stream_t mac_rx_out,
    output stream_t line_tx_out,
    input wire logic [3:0][7:0] sensor_code_in,
    input wire logic esd_strike_in,
    output logic esd_irq
);

    // next 8 bits of x^7+x^6+1 from the last 7 bits seen
    function automatic logic [7:0] prbs_next(input logic [7:0] prev);
        logic [6:0] s;
        logic nb;
        logic [7:0] o;
        s = prev[6:0];
        o = 8'h00;
        for (int i = 0; i < 8; i++) begin
            nb = s[6] ^ s[5];
            s = {s[5:0], nb};
            o[7 - i] = nb;
        end
        return o;
    endfunction : prbs_next

    // sensor select decode: {hit, index}
    function automatic logic [2:0] sel_decode(input logic [15:0] v);
        if (v == `SEL_VDDA) begin
            return 3'h4;
        end else if (v == `SEL_CORE) begin
            return 3'h5;
        end else if (v == `SEL_VDDIO) begin
            return 3'h6;
        end else if (v == `SEL_TEMP) begin
            return 3'h7;
        end else begin
            return 3'h0;
        end
    endfunction : sel_decode

    state_t s_q;
    state_t s_d;
    esd_state_t e_q;
    esd_state_t e_d;

    logic wr;
    logic rd;
    logic soft_rst;
    logic lb_analog;
    logic lb_digital;
    logic lb_pcs;
    logic lb_internal;
    logic lb_mac;
    logic lb_rev;
    logic pkt_gen;
    logic pkt_chk;
    logic prbs_mode;
    logic esd_rd;
    logic esd_edge;
    logic [2:0] sel_hit;
    logic [7:0] pay;
    stream_t tx_src;
    stream_t rx_path;
    stream_t chk_in;
    stream_t ltx;
    stream_t mrx;

    assign reg_rdata = s_q.rdata;
    assign reg_ack = s_q.ack;
    assign mac_rx_out = s_q.mac_rx;
    assign line_tx_out = s_q.line_tx_o;
    assign esd_irq = e_q.flag;
    assign esd_edge = e_q.s2 & ~e_q.s3;
    assign esd_rd = reg_req & ~reg_we & (reg_addr == `REG_ESD_EVENT_STATUS);

    always_comb begin
        s_d = s_q;
        wr = reg_req & reg_we;
        rd = reg_req & ~reg_we;
        soft_rst = wr & (reg_addr == `REG_BASIC_CONTROL)
            & reg_wdata[`BASIC_SOFT_RST_BIT];
        lb_analog = (s_q.lb == `LB_ANALOG) & (s_q.afe == `AFE_ANALOG);
        lb_digital = (s_q.lb == `LB_DIGITAL) & s_q.dfe[`DFE_DLB_BIT];
        lb_pcs = s_q.lb == `LB_PCS;
        lb_internal = lb_analog | lb_digital | lb_pcs;
        lb_mac = s_q.basic == `BASIC_XMII_LB;
        lb_rev = (s_q.lb == `LB_REVERSE) | (s_q.ser_rev == `SER_REVERSE);
        pkt_gen = ((s_q.gen_ctrl == `GEN_PKT) & (s_q.pkt_cfg == `PKT_CFG_STD))
            | (s_q.gen_ctrl == `GEN_REV_RGMII)
            | (s_q.gen_ctrl == `GEN_REV_SGMII);
        pkt_chk = pkt_gen | (s_q.gen_ctrl == `GEN_CHK_RGMII)
            | (s_q.gen_ctrl == `GEN_CHK_SGMII);
        prbs_mode = (s_q.gen_ctrl == `GEN_PRBS)
            & (s_q.pkt_cfg == `PKT_CFG_STD);

        // register writes
        s_d.ack = reg_req;
        if (wr) begin
            if (reg_addr == `REG_BASIC_CONTROL) begin
                s_d.basic = reg_wdata;
            end else if (reg_addr == `REG_INTERRUPT_ENABLE) begin
                s_d.int_en = reg_wdata;
            end else if (reg_addr == `REG_LOOPBACK_CONTROL) begin
                s_d.lb = reg_wdata;
            end else if (reg_addr == `REG_ANALOG_LOOP_CONFIG) begin
                s_d.afe = reg_wdata;
            end else if (reg_addr == `REG_LINE_TX_CONTROL) begin
                s_d.line_tx = reg_wdata;
            end else if (reg_addr == `REG_SERIAL_REVERSE_LOOP) begin
                s_d.ser_rev = reg_wdata;
            end else if (reg_addr == `REG_MONITOR_CONFIG) begin
                s_d.mon_cfg = reg_wdata;
            end else if (reg_addr == `REG_SENSOR_SELECT) begin
                s_d.sel = reg_wdata;
            end else if (reg_addr == `REG_GENERATOR_CONTROL) begin
                s_d.gen_ctrl = reg_wdata;
                s_d.gen_done = 1'b0;
                s_d.gen_sent = 4'h0;
                s_d.gen_st = GEN_OFF;
            end else if (reg_addr == `REG_PACKET_PARAMS) begin
                s_d.pkt_par = reg_wdata;
            end else if (reg_addr == `REG_PACKET_CONFIG) begin
                s_d.pkt_cfg = reg_wdata;
            end else if (reg_addr == `REG_DIGITAL_FRONTEND_CONTROL) begin
                s_d.dfe = reg_wdata;
            end
        end

        // register reads, unmapped reads as zero
        sel_hit = sel_decode(s_q.sel);
        s_d.rdata = 16'h0000;
        if (rd) begin
            if (reg_addr == `REG_BASIC_CONTROL) begin
                s_d.rdata = s_q.basic;
            end else if (reg_addr == `REG_INTERRUPT_ENABLE) begin
                s_d.rdata = s_q.int_en;
            end else if (reg_addr == `REG_LOOPBACK_CONTROL) begin
                s_d.rdata = s_q.lb;
            end else if (reg_addr == `REG_ANALOG_LOOP_CONFIG) begin
                s_d.rdata = s_q.afe;
            end else if (reg_addr == `REG_LINE_TX_CONTROL) begin
                s_d.rdata = s_q.line_tx;
            end else if (reg_addr == `REG_SERIAL_REVERSE_LOOP) begin
                s_d.rdata = s_q.ser_rev;
            end else if (reg_addr == `REG_ESD_EVENT_STATUS) begin
                s_d.rdata = {1'b0, e_q.cnt, 8'h00, e_q.flag};
            end else if (reg_addr == `REG_MONITOR_CONFIG) begin
                s_d.rdata = s_q.mon_cfg;
            end else if (reg_addr == `REG_SENSOR_SELECT) begin
                s_d.rdata = s_q.sel;
            end else if (reg_addr == `REG_SENSOR_READOUT) begin
                if (sel_hit[2]) begin
                    s_d.rdata = {1'b0, s_q.samples[sel_hit[1:0]], 7'h00};
                end
            end else if (reg_addr == `REG_GENERATOR_CONTROL) begin
                s_d.rdata = s_q.gen_ctrl;
            end else if (reg_addr == `REG_PACKET_PARAMS) begin
                s_d.rdata = s_q.pkt_par;
            end else if (reg_addr == `REG_PRBS_CHECKER) begin
                s_d.rdata = {7'h00, s_q.prbs_lock, s_q.prbs_err};
            end else if (reg_addr == `REG_PACKET_CONFIG) begin
                s_d.rdata = s_q.pkt_cfg;
            end else if (reg_addr == `REG_RX_PACKET_COUNT_LOW) begin
                s_d.rdata = s_q.rx_cnt[15:0];
            end else if (reg_addr == `REG_RX_PACKET_COUNT_HIGH) begin
                s_d.rdata = s_q.rx_cnt[31:16];
            end else if (reg_addr == `REG_RX_CRC_ERROR_COUNT) begin
                s_d.rdata = s_q.crc_cnt;
            end else if (reg_addr == `REG_DIGITAL_FRONTEND_CONTROL) begin
                s_d.rdata = s_q.dfe;
            end
        end

        // packet / PRBS generator
        if (s_q.pkt_cfg[1]) begin
            pay = prbs_next(s_q.gen_lfsr);
        end else if (s_q.pkt_cfg[0]) begin
            pay = s_q.pkt_cfg[`PC_FIX_MSB:`PC_FIX_LSB];
        end else begin
            pay = s_q.gen_idx;
        end
        s_d.gen_out = '0;
        if (!(pkt_gen | prbs_mode) | s_q.gen_done) begin
            s_d.gen_st = GEN_OFF;
        end else begin
            case (s_q.gen_st)
                GEN_OFF: begin
                    s_d.gen_st = GEN_DATA;
                    s_d.gen_idx = 8'h00;
                    s_d.gen_sum = 8'h00;
                end
                GEN_DATA: begin
                    if (prbs_mode) begin
                        s_d.gen_out = '{1'b1, 1'b0, prbs_next(s_q.gen_lfsr)};
                        s_d.gen_lfsr = prbs_next(s_q.gen_lfsr);
                    end else begin
                        s_d.gen_out = '{1'b1, 1'b0, pay};
                        s_d.gen_sum = s_q.gen_sum ^ pay;
                        s_d.gen_lfsr = s_q.pkt_cfg[1] ? pay : s_q.gen_lfsr;
                        s_d.gen_idx = s_q.gen_idx + 8'h01;
                        if (s_q.gen_idx == s_q.pkt_par[`PP_LEN_MSB:0]) begin
                            s_d.gen_st = GEN_SUM;
                        end
                    end
                end
                GEN_SUM: begin
                    s_d.gen_out = '{1'b1, 1'b1, s_q.gen_sum};
                    s_d.gen_sent = s_q.gen_sent + 4'h1;
                    s_d.gen_gap = s_q.pkt_par[`PP_IPG_MSB:`PP_IPG_LSB];
                    s_d.gen_st = GEN_GAP;
                    if (s_q.pkt_par[`PP_CNT_MSB:`PP_CNT_LSB] != 4'h0
                        && s_q.gen_sent + 4'h1
                        == s_q.pkt_par[`PP_CNT_MSB:`PP_CNT_LSB]) begin
                        s_d.gen_done = 1'b1;
                    end
                end
                GEN_GAP: begin
                    s_d.gen_gap = s_q.gen_gap - 4'h1;
                    if (s_q.gen_gap == 4'h0) begin
                        s_d.gen_st = GEN_OFF;
                    end
                end
                default: s_d.gen_st = GEN_OFF;
            endcase
        end

        // datapath steering
        tx_src = (pkt_gen | prbs_mode) ? s_q.gen_out : mac_tx_in;
        s_d.loop = tx_src;
        rx_path = lb_internal ? s_q.loop : line_rx_in;
        chk_in = lb_mac ? mac_tx_in : rx_path;
        ltx = tx_src;
        if (lb_rev) begin
            ltx = (pkt_gen | prbs_mode) ? s_q.gen_out : line_rx_in;
        end
        if (s_q.line_tx == `LINE_TX_OFF) begin
            ltx.valid = 1'b0;
        end
        s_d.line_tx_o = ltx;
        mrx = chk_in;
        if (s_q.basic == `BASIC_MAC_OFF) begin
            mrx.valid = 1'b0;
        end
        s_d.mac_rx = mrx;

        // packet checker
        if (pkt_chk & chk_in.valid) begin
            if (chk_in.last) begin
                s_d.rx_cnt = s_q.rx_cnt + 32'h1;
                s_d.chk_sum = 8'h00;
                if (chk_in.data != s_q.chk_sum
                    && s_q.crc_cnt != 16'hffff) begin
                    s_d.crc_cnt = s_q.crc_cnt + 16'h1;
                end
            end else begin
                s_d.chk_sum = s_q.chk_sum ^ chk_in.data;
            end
        end

        // PRBS checker, internal generator only
        if (wr && reg_addr == `REG_PRBS_CHECKER) begin
            s_d.prbs_en = reg_wdata[`PRBS_ENABLE_BIT];
            s_d.prbs_err = 8'h00;
        end
        if (!prbs_mode) begin
            s_d.prbs_lock = 1'b0;
            s_d.lock_cnt = 3'h0;
        end else if (chk_in.valid) begin
            s_d.prbs_prev = chk_in.data;
            if (chk_in.data == prbs_next(s_q.prbs_prev)) begin
                if (s_q.lock_cnt == `LOCK_MATCHES) begin
                    s_d.prbs_lock = 1'b1;
                end else begin
                    s_d.lock_cnt = s_q.lock_cnt + 3'h1;
                end
            end else if (s_q.prbs_lock) begin
                if (s_q.prbs_en && s_q.prbs_err != 8'hff) begin
                    s_d.prbs_err = s_q.prbs_err + 8'h01;
                end
            end else begin
                s_d.lock_cnt = 3'h0;
            end
        end

        // sensor monitor, always polling
        s_d.sens_s1 = sensor_code_in;
        s_d.sens_s2 = s_q.sens_s1;
        if (wr && reg_addr == `REG_MONITOR_REFRESH) begin
            s_d.refresh_armed = reg_wdata == `REFRESH_ARM;
        end
        case (s_q.mon_st)
            MON_IDLE: begin
                s_d.mon_st = MON_WAIT;
                s_d.mon_timer = 16'h0000;
            end
            MON_WAIT: begin
                s_d.mon_timer = s_q.mon_timer + 16'h0001;
                if (s_q.mon_timer == 16'(`MON_POLL_CYC - 1)) begin
                    s_d.mon_st = MON_SAMPLE;
                end
            end
            MON_SAMPLE: begin
                s_d.samples[s_q.mon_idx] = s_q.sens_s2[s_q.mon_idx];
                s_d.mon_timer = 16'h0000;
                s_d.mon_st = MON_WAIT;
                s_d.mon_prio_slot = ~s_q.mon_prio_slot;
                if (s_q.mon_cfg[`MON_PRIO_EN_BIT] & ~s_q.mon_prio_slot) begin
                    s_d.mon_idx = s_q.mon_cfg[1:0];
                end else begin
                    // own pointer, so priority slots never starve the rest
                    s_d.mon_idx = s_q.mon_rr;
                    s_d.mon_rr = s_q.mon_rr + 2'h1;
                end
            end
            default: s_d.mon_st = MON_IDLE;
        endcase
        if (wr && reg_addr == `REG_MONITOR_REFRESH
            && reg_wdata == `REFRESH_GO && s_q.refresh_armed) begin
            s_d.mon_st = MON_SAMPLE;
            s_d.mon_idx = 2'h0;
            s_d.mon_rr = 2'h1;
            s_d.mon_prio_slot = 1'b1;
        end

        if (soft_rst) begin
            s_d = '0;
            s_d.gen_lfsr = `PRBS_SEED;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
            s_q.gen_lfsr <= `PRBS_SEED;
        end else begin
            s_q <= s_d;
        end
    end

    // ESD logging on power-on reset only
    always_comb begin
        e_d = e_q;
        e_d.s1 = esd_strike_in;
        e_d.s2 = e_q.s1;
        e_d.s3 = e_q.s2;
        if (esd_rd) begin
            e_d.flag = 1'b0;
        end
        if (esd_edge) begin
            if (e_q.cnt != 6'h3f) begin
                e_d.cnt = e_q.cnt + 6'h01;
            end
            if (s_q.int_en[`INT_ESD_BIT]) begin
                e_d.flag = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge por_n) begin
        if (!por_n) begin
            e_q <= '0;
        end else begin
            e_q <= e_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    chk_mac_block: assert property ((s_q.basic == `BASIC_MAC_OFF)
        |=> !mac_rx_out.valid) else $error("mac side not blocked");
    chk_line_block: assert property ((s_q.line_tx == `LINE_TX_OFF)
        |=> !line_tx_out.valid) else $error("cable not blocked");
    chk_internal_loop: assert property (lb_internal && !lb_mac
        && s_q.basic != `BASIC_MAC_OFF && !soft_rst
        |=> mac_rx_out == $past(s_q.loop))
        else $error("internal loop not routed");
    chk_mac_loop: assert property (lb_mac && !soft_rst
        |=> mac_rx_out == $past(mac_tx_in))
        else $error("mac loop not routed");
    chk_rx_count: assert property (pkt_chk && chk_in.valid && chk_in.last
        && !soft_rst |=> s_q.rx_cnt == $past(s_q.rx_cnt) + 32'h1)
        else $error("packet not counted");
    chk_prbs_ext: assert property (!prbs_mode |=> (!s_q.prbs_lock)[*2])
        else $error("lock without internal prbs");
    chk_prbs_readback: assert property (rd
        && reg_addr == `REG_PRBS_CHECKER
        |=> reg_rdata[8] == $past(s_q.prbs_lock) && reg_ack)
        else $error("prbs status wrong");
    chk_sensor_readout: assert property (rd
        && reg_addr == `REG_SENSOR_READOUT && sel_hit[2]
        |=> reg_rdata[14:7] == $past(s_q.samples[sel_hit[1:0]]))
        else $error("sensor code wrong");
    chk_esd_sat: assert property (@(posedge clk) disable iff (!por_n)
        e_q.cnt == 6'h3f |=> e_q.cnt == 6'h3f)
        else $error("esd count wrapped");
    chk_esd_flag: assert property (@(posedge clk) disable iff (!por_n)
        esd_edge && s_q.int_en[`INT_ESD_BIT] |=> esd_irq)
        else $error("esd flag lost");

    cov_pkt_rx: cover property (pkt_gen && lb_internal && chk_in.last);
    cov_prbs_lock: cover property ($rose(s_q.prbs_lock));
    cov_esd: cover property (@(posedge clk) disable iff (!por_n) esd_edge);
    cov_mac_loop: cover property (lb_mac && mac_tx_in.valid);

endmodule : phy_datapath_bist_and_monitors

// ---- rtl/bist_defs.svh ----
`ifndef BIST_DEFS_SVH
`define BIST_DEFS_SVH

// register offsets
`define REG_BASIC_CONTROL 16'h0000
`define REG_INTERRUPT_ENABLE 16'h0012
`define REG_LOOPBACK_CONTROL 16'h0016
`define REG_ANALOG_LOOP_CONFIG 16'h0405
`define REG_LINE_TX_CONTROL 16'h041f
`define REG_SERIAL_REVERSE_LOOP 16'h042c
`define REG_ESD_EVENT_STATUS 16'h0442
`define REG_MONITOR_CONFIG 16'h0467
`define REG_SENSOR_SELECT 16'h0468
`define REG_MONITOR_REFRESH 16'h046a
`define REG_SENSOR_READOUT 16'h047b
`define REG_GENERATOR_CONTROL 16'h0619
`define REG_PACKET_PARAMS 16'h061b
`define REG_PRBS_CHECKER 16'h0620
`define REG_PACKET_CONFIG 16'h0624
`define REG_RX_PACKET_COUNT_LOW 16'h063c
`define REG_RX_PACKET_COUNT_HIGH 16'h063d
`define REG_RX_CRC_ERROR_COUNT 16'h063e
`define REG_DIGITAL_FRONTEND_CONTROL 16'h0800

// control values
`define LB_ANALOG 16'h0108
`define AFE_ANALOG 16'h2800
`define LB_DIGITAL 16'h0104
`define DFE_DLB_BIT 11
`define LB_PCS 16'h0101
`define LB_REVERSE 16'h0010
`define SER_REVERSE 16'h0010
`define BASIC_XMII_LB 16'h4140
`define BASIC_MAC_OFF 16'h0540
`define BASIC_SOFT_RST_BIT 15
`define LINE_TX_OFF 16'h1000
`define GEN_PKT 16'h1555
`define GEN_PRBS 16'h0557
`define GEN_CHK_RGMII 16'h1004
`define GEN_CHK_SGMII 16'h1114
`define GEN_REV_RGMII 16'h1005
`define GEN_REV_SGMII 16'h1115
`define PKT_CFG_STD 16'h55bf
`define PRBS_ENABLE_BIT 1
`define INT_ESD_BIT 3
`define MON_INIT 16'h6004
`define MON_PRIO_EN_BIT 2
`define REFRESH_ARM 16'h00a6
`define REFRESH_GO 16'h00a3
`define SEL_VDDA 16'h1920
`define SEL_CORE 16'h2920
`define SEL_VDDIO 16'h3920
`define SEL_TEMP 16'h4920

// field positions
`define PP_LEN_MSB 7
`define PP_IPG_LSB 8
`define PP_IPG_MSB 11
`define PP_CNT_LSB 12
`define PP_CNT_MSB 15
`define PC_FIX_LSB 8
`define PC_FIX_MSB 15
`define READOUT_LSB 7
`define READOUT_MSB 14
`define ESD_CNT_LSB 9
`define ESD_CNT_MSB 14

// reset values and timing
`define PRBS_SEED 8'hff
`define LOCK_MATCHES 3'h7
`define CLK_PERIOD_NS 10
`define MON_POLL_NS 2000
`define MON_POLL_CYC ((`MON_POLL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ---- rtl/bist_pkg.sv ----
package bist_pkg;

typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
} stream_t;

typedef enum logic [1:0] {
    GEN_OFF = 2'b00,
    GEN_DATA = 2'b01,
    GEN_SUM = 2'b10,
    GEN_GAP = 2'b11
} gen_state_t;

typedef enum logic [1:0] {
    MON_IDLE = 2'b00,
    MON_WAIT = 2'b01,
    MON_SAMPLE = 2'b10
} mon_state_t;

typedef struct packed {
    logic [15:0] basic;
    logic [15:0] int_en;
    logic [15:0] lb;
    logic [15:0] afe;
    logic [15:0] line_tx;
    logic [15:0] ser_rev;
    logic [15:0] mon_cfg;
    logic [15:0] sel;
    logic [15:0] gen_ctrl;
    logic [15:0] pkt_par;
    logic [15:0] pkt_cfg;
    logic [15:0] dfe;
    logic prbs_en;
    logic [31:0] rx_cnt;
    logic [15:0] crc_cnt;
    logic [7:0] prbs_err;
    logic prbs_lock;
    logic [2:0] lock_cnt;
    logic [7:0] prbs_prev;
    gen_state_t gen_st;
    logic gen_done;
    logic [7:0] gen_idx;
    logic [3:0] gen_sent;
    logic [3:0] gen_gap;
    logic [7:0] gen_lfsr;
    logic [7:0] gen_sum;
    stream_t gen_out;
    logic [7:0] chk_sum;
    mon_state_t mon_st;
    logic [15:0] mon_timer;
    logic [1:0] mon_idx;
    logic [1:0] mon_rr;
    logic mon_prio_slot;
    logic refresh_armed;
    logic [3:0][7:0] sens_s1;
    logic [3:0][7:0] sens_s2;
    logic [3:0][7:0] samples;
    stream_t loop;
    stream_t mac_rx;
    stream_t line_tx_o;
    logic [15:0] rdata;
    logic ack;
} state_t;

typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic [5:0] cnt;
    logic flag;
} esd_state_t;

endpackage : bist_pkg

// ---- tb/mac_model.sv ----
module mac_model
    import bist_pkg::*;
(
    input wire logic clk,
    input wire logic go,
    input wire logic bad,
    output stream_t tx
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] pay [3] = '{8'h11, 8'h22, 8'h5a};
    initial tx = '0;
    // payload then xor check byte, bad inverts check
    always @(posedge go) begin
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            #1;
            tx.valid = 1'b1;
            tx.last = (i == 3);
            tx.data = (i < 3) ? pay[i] : 8'h69 ^ {8{bad}};
        end
        @(posedge clk);
        #1;
        tx = '{1'b0, 1'b0, ~tx.data};
    end
endmodule : mac_model

// ---- tb/test_phy_datapath_bist_and_monitors.sv ----
module test_phy_datapath_bist_and_monitors
    import bist_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [3:0][7:0] CODES = 32'ha15de080;
    logic clk = 0, resetn = 0, por_n = 0, req = 0, we = 0;
    logic go = 0, bad = 0, strk = 0, ack, irq;
    logic [15:0] addr = '0, wd = '0, rdat;
    stream_t mtx, mrx, ltx;
    stream_t lrx = '0;
    int err_total = 0, n_compared = 0, cyc = 0;
    always #5 clk = ~clk;
    mac_model u_mac (.clk(clk), .go(go), .bad(bad), .tx(mtx));
    phy_datapath_bist_and_monitors u_dut (.clk(clk), .resetn(resetn),
        .por_n(por_n), .reg_req(req), .reg_we(we), .reg_addr(addr),
        .reg_wdata(wd), .reg_rdata(rdat), .reg_ack(ack), .mac_tx_in(mtx),
        .line_rx_in(lrx), .mac_rx_out(mrx), .line_tx_out(ltx),
        .sensor_code_in(CODES), .esd_strike_in(strk), .esd_irq(irq));
    task automatic chk(logic [15:0] got, logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
            err_total++;
        end
    endtask : chk
    task automatic acc(logic w, logic [15:0] a, logic [15:0] d,
                       logic [15:0] exp);
        req = 1; we = w; addr = a; wd = d;
        @(posedge clk);
        #1;
        req = 0;
        chk({15'h0, ack}, 16'h1);
        if (!w) chk(rdat, exp);
        @(posedge clk);
        #1;
    endtask : acc
    task automatic wr(logic [15:0] a, logic [15:0] d);
        acc(1, a, d, 16'h0);
    endtask : wr
    task automatic rd(logic [15:0] a, logic [15:0] exp);
        acc(0, a, 16'h0, exp);
    endtask : rd
    task automatic strike(int n);
        repeat (n) begin
            strk = 1;
            repeat (4) @(posedge clk);
            #1 strk = 0;
            repeat (4) @(posedge clk);
            #1;
        end
    endtask : strike
    task automatic frame(logic b);
        bad = b;
        go = 1;
        @(posedge clk);
        #1 go = 0;
        @(posedge clk);
        #1;
        chk(16'(mrx), 16'h0211);
        repeat (9) @(posedge clk);
        #1;
    endtask : frame
    task automatic complete_run;
        $display("compared %0d errors %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : complete_run
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            complete_run();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        #1 resetn = 1;
        por_n = 1;
        rd(16'h0016, 16'h0);
        rd(16'h1234, 16'h0);
        wr(16'h063c, 16'h0005);
        rd(16'h063c, 16'h0);
        wr(16'h0012, 16'h0008);
        strike(3);
        chk({15'h0, irq}, 16'h1);
        resetn = 0;
        @(posedge clk);
        #1 resetn = 1;
        wr(16'h0012, 16'h0008);
        rd(16'h0442, 16'h0601);
        rd(16'h0442, 16'h0600);
        chk({15'h0, irq}, 16'h0);
        strike(63);
        rd(16'h0442, 16'h7e01);
        // monitor bring-up, then each sensor in turn
        wr(16'h0467, 16'h6004);
        wr(16'h046a, 16'h00a6);
        wr(16'h046a, 16'h00a3);
        repeat (1100) @(posedge clk);
        #1;
        for (int i = 0; i < 4; i++) begin
            wr(16'h0468, 16'h1920 + 16'(i << 12));
            rd(16'h047b, {1'b0, CODES[i], 7'h0});
        end
        wr(16'h0000, 16'h4140);
        wr(16'h0619, 16'h1004);
        frame(0);
        frame(1);
        rd(16'h063c, 16'h0002);
        rd(16'h063d, 16'h0000);
        rd(16'h063e, 16'h0001);
        wr(16'h0000, 16'h0000);
        wr(16'h0016, 16'h0108);
        wr(16'h0405, 16'h2800);
        wr(16'h0624, 16'h55bf);
        wr(16'h0619, 16'h0557);
        wr(16'h0620, 16'h0002);
        repeat (100) @(posedge clk);
        #1;
        rd(16'h0620, 16'h0100);
        // reverse loop with generator off, then cable blocked
        wr(16'h0619, 16'h0000);
        wr(16'h0016, 16'h0010);
        lrx = '{1'b1, 1'b0, 8'hc3};
        @(posedge clk);
        #1;
        chk(16'(ltx), 16'h02c3);
        wr(16'h041f, 16'h1000);
        chk(16'(ltx), 16'h00c3);
        complete_run();
    end
endmodule : test_phy_datapath_bist_and_monitors
